/* design/i2c_master_sequencer.sv */
`timescale 1ns/1ps
// How it works
// R1: software picks master mode, then enables port
// R2: start/stop seen cleared on reset, disable
// R3: pins open-drain; device only pulls low
// R4: software takes bus on stop or idle
// R5: firmware mode keeps only start/stop detection
// R6: irq flag on start, stop, byte, ack, restart; a detected stop sets it only in firmware mode
// R7: master mode irq when request self-clears
// R8: no queuing; early buffer write collides
// R9: control two low bits locked until start
// R10: first byte is address plus direction bit
// R11: released scl stalls baud until sampled high
// R12: start waits one period, then sda low
// R13: one more period, clear start request
// R14: start collision on low lines aborts
// R15: restart ignored while other event busy
// R16: restart: scl low, release sda, release scl
// R17: lines high one period, sda low period
// R18: restart ends, irq after generator timeout
// R19: restart collision on sda low or scl
// R20: buffer write sets full, shifts bits
// R21: after eighth fall clear full, store ack
// R22: after ninth clock irq, hold scl low
// R23: write while busy collides; software clears
// R24: baud counts down, timeout at zero
module i2c_master_sequencer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic port_enable_bit,
  input wire logic [3:0] port_mode_select,
  input wire logic [7:0] baud_reload_reg,
  input wire logic [7:0] transfer_buffer,
  input wire logic buffer_write,
  input wire logic [4:0] ctrl2_write_data,
  input wire logic ctrl2_write,
  input wire logic irq_clear,
  input wire logic bus_collision_clear,
  input wire logic write_collision_clear,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic [4:0] control_reg_two,
  output logic start_seen,
  output logic stop_seen,
  output logic buffer_full,
  output logic ack_status,
  output logic port_irq_flag,
  output logic write_collision_flag,
  output logic bus_collision_flag
);
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_START_WAIT = 9'h002,
    ST_START_HOLD = 9'h004,
    ST_RS_LOW = 9'h008,
    ST_RS_SDA = 9'h010,
    ST_RS_HIGH = 9'h020,
    ST_RS_HOLD = 9'h040,
    ST_TX_LOW = 9'h080,
    ST_TX_HIGH = 9'h100
  } state_e;

  state_e state;
  state_e next_state;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_s;
  logic sda_s;
  logic next_scl_s;
  logic next_sda_s;
  logic scl_prev;
  logic sda_prev;
  logic [7:0] shift_register;
  logic [7:0] next_shift;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic next_scl_low;
  logic next_sda_low;
  logic waiting_high;
  logic next_waiting_high;
  logic [4:0] next_ctrl2;
  logic next_start_seen;
  logic next_stop_seen;
  logic next_full;
  logic next_ack;
  logic next_irq;
  logic next_write_col;
  logic next_bcol;
  logic baud_load;
  logic baud_run;
  logic baud_tmo;
  logic master_on;
  logic fw_mode;

  baud_gen u_baud (
    .core_clk(core_clk),
    .rst(rst),
    .load(baud_load),
    .run(baud_run),
    .reload(baud_reload_reg),
    .timeout(baud_tmo)
  );

  // software picks the mode before enabling; block only acts once both agree
  assign master_on = port_enable_bit && (port_mode_select == i2c_master_pkg::MODE_MASTER); // [R1]
  assign fw_mode = port_enable_bit && (port_mode_select == i2c_master_pkg::MODE_FW_MASTER);

  // pin filter: a change counts once the last two stages agree
  always_comb begin
    next_scl_s = scl_s;
    next_sda_s = sda_s;
    if (scl_sync[1] == scl_sync[2]) begin
      next_scl_s = scl_sync[2];
    end
    if (sda_sync[1] == sda_sync[2]) begin
      next_sda_s = sda_sync[2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_s <= next_scl_s;
      sda_s <= next_sda_s;
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  always_comb begin
    next_state = state;
    next_shift = shift_register;
    next_bit_idx = bit_idx;
    next_scl_low = scl_oe;
    next_sda_low = sda_oe;
    next_waiting_high = waiting_high;
    next_ctrl2 = control_reg_two;
    next_start_seen = start_seen;
    next_stop_seen = stop_seen;
    next_full = buffer_full;
    next_ack = ack_status;
    // clears go first so that an event set below in the same cycle wins
    next_irq = port_irq_flag && !irq_clear;
    next_write_col = write_collision_flag && !write_collision_clear; // [R23]
    next_bcol = bus_collision_flag && !bus_collision_clear;
    baud_load = 1'b0;
    // released scl freezes the generator until it is seen high
    baud_run = (state != ST_IDLE) && !waiting_high; // [R11]

    // start and stop detection on the bus lines
    if (scl_s && scl_prev && sda_prev && !sda_s) begin
      next_start_seen = 1'b1;
      next_stop_seen = 1'b0;
      if (fw_mode) begin
        next_irq = 1'b1; // [R5] [R6]
      end
    end
    if (scl_s && scl_prev && !sda_prev && sda_s) begin
      next_stop_seen = 1'b1;
      next_start_seen = 1'b0;
      // in master mode this detection is masked from the irq
      if (fw_mode) begin
        next_irq = 1'b1; // [R5] [R6]
      end
    end

    if (waiting_high && scl_s) begin
      next_waiting_high = 1'b0;
      baud_load = 1'b1; // [R11]
    end

    // requests locked while a start is pending; no queuing
    if (ctrl2_write && master_on && state == ST_IDLE
        && !control_reg_two[i2c_master_pkg::START_BIT]) begin
      next_ctrl2 = ctrl2_write_data & i2c_master_pkg::CTRL2_LOW_MASK; // [R9] [R15]
    end

    if (buffer_write && master_on) begin
      if (state != ST_IDLE || control_reg_two != 5'h00) begin
        next_write_col = 1'b1; // [R8] [R23]
      end else begin
        // address byte carries the direction in bit 0, sent as given
        next_shift = transfer_buffer; // [R10]
        next_full = 1'b1; // [R20]
        next_bit_idx = 4'h0;
        next_scl_low = 1'b1;
        baud_load = 1'b1;
        next_state = ST_TX_LOW;
      end
    end

    unique case (state)
      ST_IDLE: begin
        if (master_on && control_reg_two[i2c_master_pkg::START_BIT]) begin
          if (scl_s && sda_s) begin
            baud_load = 1'b1; // [R12]
            next_state = ST_START_WAIT;
          end else begin
            next_bcol = 1'b1; // [R14]
            next_ctrl2[i2c_master_pkg::START_BIT] = 1'b0;
          end
        end else if (master_on && control_reg_two[i2c_master_pkg::RESTART_BIT]) begin
          next_scl_low = 1'b1; // [R16]
          next_state = ST_RS_LOW;
        end
      end
      ST_START_WAIT: begin
        if (!scl_s) begin
          next_bcol = 1'b1; // [R14]
          next_ctrl2[i2c_master_pkg::START_BIT] = 1'b0;
          next_state = ST_IDLE;
        end else if (baud_tmo && sda_s) begin
          next_sda_low = 1'b1; // [R12]
          next_start_seen = 1'b1;
          baud_load = 1'b1; // [R13]
          next_state = ST_START_HOLD;
        end
      end
      ST_START_HOLD: begin
        if (baud_tmo) begin
          next_ctrl2[i2c_master_pkg::START_BIT] = 1'b0; // [R13]
          next_irq = 1'b1; // [R6] [R7]
          next_state = ST_IDLE;
        end
      end
      ST_RS_LOW: begin
        if (!scl_s) begin
          next_sda_low = 1'b0; // [R16]
          baud_load = 1'b1;
          next_state = ST_RS_SDA;
        end
      end
      ST_RS_SDA: begin
        if (baud_tmo && sda_s) begin
          next_scl_low = 1'b0; // [R16]
          next_waiting_high = 1'b1;
          next_state = ST_RS_HIGH;
        end
      end
      ST_RS_HIGH: begin
        if (!waiting_high && !sda_s) begin
          next_bcol = 1'b1; // [R19]
          next_ctrl2[i2c_master_pkg::RESTART_BIT] = 1'b0;
          next_state = ST_IDLE;
        end else if (baud_tmo && scl_s && sda_s) begin
          next_sda_low = 1'b1; // [R17]
          next_state = ST_RS_HOLD;
        end
      end
      ST_RS_HOLD: begin
        if (!scl_s) begin
          next_bcol = 1'b1; // [R19]
          next_ctrl2[i2c_master_pkg::RESTART_BIT] = 1'b0;
          next_state = ST_IDLE;
        end else if (baud_tmo) begin
          next_scl_low = 1'b1; // [R17]
          next_ctrl2[i2c_master_pkg::RESTART_BIT] = 1'b0; // [R18]
          next_irq = 1'b1; // [R6] [R18]
          next_state = ST_IDLE;
        end
      end
      ST_TX_LOW: begin
        if (bit_idx < i2c_master_pkg::LAST_BIT) begin
          next_sda_low = !shift_register[7]; // [R20]
        end else begin
          next_sda_low = 1'b0; // [R21]
          next_full = 1'b0;
        end
        if (baud_tmo) begin
          next_scl_low = 1'b0; // [R20]
          next_waiting_high = 1'b1;
          next_state = ST_TX_HIGH;
        end
      end
      ST_TX_HIGH: begin
        if (baud_tmo) begin
          next_scl_low = 1'b1;
          if (bit_idx == i2c_master_pkg::LAST_BIT) begin
            next_ack = sda_s; // [R21]
            next_irq = 1'b1; // [R6] [R22]
            next_state = ST_IDLE; // [R22]
          end else begin
            next_shift = {shift_register[6:0], 1'b0};
            next_bit_idx = bit_idx + 4'h1;
            baud_load = 1'b1;
            next_state = ST_TX_LOW;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    if (!port_enable_bit) begin
      next_start_seen = 1'b0; // [R2]
      next_stop_seen = 1'b0;
      next_state = ST_IDLE;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      next_waiting_high = 1'b0;
      next_ctrl2 = 5'h00;
      next_full = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      shift_register <= 8'h00;
      bit_idx <= 4'h0;
      waiting_high <= 1'b0;
      control_reg_two <= 5'h00;
      start_seen <= 1'b0; // [R2]
      stop_seen <= 1'b0;
      buffer_full <= 1'b0;
      ack_status <= 1'b0;
      port_irq_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
    end else begin
      state <= next_state;
      shift_register <= next_shift;
      bit_idx <= next_bit_idx;
      waiting_high <= next_waiting_high;
      control_reg_two <= next_ctrl2;
      start_seen <= next_start_seen;
      stop_seen <= next_stop_seen;
      buffer_full <= next_full;
      ack_status <= next_ack;
      port_irq_flag <= next_irq;
      write_collision_flag <= next_write_col;
      bus_collision_flag <= next_bcol;
    end
  end

  // open drain: only ever pull low, enable is the drive flag itself
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe <= next_scl_low; // [R3]
      sda_out <= 1'b0;
      sda_oe <= next_sda_low; // [R3]
    end
  end
endmodule

/* pkg/i2c_master_pkg.sv */
package i2c_master_pkg;
  localparam int BAUD_W = 8;
  localparam logic [7:0] BAUD_RESET = 8'h09;
  localparam logic [1:0] MODE_W = 2'h2;
  // port_mode_select codes, four-bit field
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_FW_MASTER = 4'hB;
  localparam int BIT_COUNT = 8;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [4:0] CTRL2_LOW_MASK = 5'h1F;
  // control_reg_two request bit positions
  localparam int START_BIT = 0;
  localparam int RESTART_BIT = 1;
  localparam logic [7:0] BAUD_ZERO = 8'h00;
endpackage

/* design/baud_gen.sv */
`timescale 1ns/1ps
// down counter: load restarts it, timeout pulses when it reaches zero while running
module baud_gen (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic run,
  input wire logic [7:0] reload,
  output logic timeout
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_timeout;

  always_comb begin
    next_count = count;
    next_timeout = 1'b0;
    if (load) begin
      next_count = reload;
    end else if (run) begin
      if (count == i2c_master_pkg::BAUD_ZERO) begin
        next_timeout = 1'b1; // [R24]
        next_count = reload;
      end else begin
        next_count = count - 8'h01; // [R24]
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= 8'h00;
      timeout <= 1'b0;
    end else begin
      count <= next_count;
      timeout <= next_timeout;
    end
  end
endmodule

/* testbench/i2c_master_sequencer_monitor.sv */
`timescale 1ns/1ps
module i2c_master_sequencer_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic port_enable_bit,
  input wire logic buffer_write,
  input wire logic ctrl2_write,
  input wire logic [4:0] ctrl2_write_data,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [4:0] control_reg_two,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic buffer_full,
  input wire logic port_irq_flag,
  input wire logic write_collision_flag,
  input wire logic bus_collision_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // enable is sampled with the fall, so a disable mid-start is left out
  sequence s_start_done;
    port_enable_bit ##0 $fell(control_reg_two[0]);
  endsequence
  a_open_drain_pins: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_disable_clears_seen: assert property (!port_enable_bit [*2] |-> !start_seen && !stop_seen)
    else $error("seen bits kept while disabled");
  a_start_pend_collide: assert property (buffer_write && control_reg_two[0]
    |=> write_collision_flag)
    else $error("write during start not flagged");
  a_busy_write_collide: assert property (buffer_write && buffer_full
    |=> write_collision_flag)
    else $error("write during transmit not flagged");
  a_ctrl2_upper_locked: assert property (ctrl2_write && control_reg_two[0]
    |=> control_reg_two[4:1] == $past(control_reg_two[4:1]))
    else $error("request bits written during start");
  a_restart_busy_ignored: assert property (ctrl2_write && ctrl2_write_data[1] && buffer_full
    |=> !control_reg_two[1])
    else $error("restart taken while busy");
  a_start_done_irq: assert property (s_start_done |-> ##[0:1] (port_irq_flag || bus_collision_flag))
    else $error("no irq at start completion");
  a_start_keeps_sda: assert property (s_start_done |-> ##[0:1] (sda_oe || bus_collision_flag))
    else $error("sda released at start completion");
  a_full_release_sda: assert property ($fell(buffer_full) |-> ##[0:1] !sda_oe)
    else $error("sda held after eighth bit");
endmodule
bind i2c_master_sequencer i2c_master_sequencer_monitor u_monitor (.core_clk(core_clk),
  .rst(rst), .port_enable_bit(port_enable_bit), .buffer_write(buffer_write),
  .ctrl2_write(ctrl2_write), .ctrl2_write_data(ctrl2_write_data), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .control_reg_two(control_reg_two),
  .start_seen(start_seen), .stop_seen(stop_seen), .buffer_full(buffer_full),
  .port_irq_flag(port_irq_flag), .write_collision_flag(write_collision_flag),
  .bus_collision_flag(bus_collision_flag));

/* testbench/i2c_slave_model.sv */
`timescale 1ns/1ps
module i2c_slave_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic nack,
  input wire logic stretch,
  input wire logic hold_low,
  output logic scl_in,
  output logic sda_in,
  output logic [7:0] rx_byte
);
  logic prev_scl;
  logic prev_sda;
  logic ack_low;
  logic [3:0] rises;
  logic [2:0] slow;
  // pull-ups: a released line reads high, any party pulls it low
  assign scl_in = !(scl_oe || hold_low || slow != 3'h0);
  assign sda_in = !(sda_oe || hold_low || ack_low);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      ack_low <= 1'b0;
      rises <= 4'h0;
      slow <= 3'h0;
      rx_byte <= 8'h00;
    end else begin
      prev_scl <= scl_in;
      prev_sda <= sda_in;
      if (slow != 3'h0) slow <= slow - 3'h1;
      if (scl_in && prev_sda && !sda_in) begin
        rises <= 4'h0;
      end else if (scl_in && !prev_scl) begin
        rises <= (rises == 4'h9) ? 4'h1 : rises + 4'h1;
        if (rises < 4'h8) rx_byte <= {rx_byte[6:0], sda_in};
      end else if (!scl_in && prev_scl) begin
        if (rises == 4'h8) ack_low <= !nack;
        if (rises == 4'h9) ack_low <= 1'b0;
        // stretching holds scl after the master lets go
        if (stretch) slow <= 3'h6;
      end
    end
  end
endmodule

/* testbench/i2c_master_sequencer_tb.sv */
`timescale 1ns/1ps
module i2c_master_sequencer_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic port_enable_bit = 1'b0;
  logic [3:0] port_mode_select = i2c_master_pkg::MODE_MASTER;
  logic [7:0] baud_reload_reg = 8'h03;
  logic [7:0] transfer_buffer = 8'h00;
  logic buffer_write = 1'b0;
  logic [4:0] ctrl2_write_data = 5'h00;
  logic ctrl2_write = 1'b0;
  logic irq_clear = 1'b0;
  logic bc_clr = 1'b0;
  logic wc_clr = 1'b0;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  logic hold_low = 1'b0;
  logic scl_in, sda_in, scl_oe, sda_oe, start_seen, buffer_full, ack_status;
  logic port_irq_flag, write_collision_flag, bus_collision_flag;
  logic [4:0] control_reg_two;
  logic [7:0] rx_byte;
  int fail_count = 0;
  int cmp_count = 0;
  always #20 core_clk = !core_clk;
  i2c_master_sequencer dut (.core_clk(core_clk), .rst(rst), .port_enable_bit(port_enable_bit),
    .port_mode_select(port_mode_select), .baud_reload_reg(baud_reload_reg),
    .transfer_buffer(transfer_buffer), .buffer_write(buffer_write),
    .ctrl2_write_data(ctrl2_write_data), .ctrl2_write(ctrl2_write), .irq_clear(irq_clear),
    .bus_collision_clear(bc_clr), .write_collision_clear(wc_clr), .scl_in(scl_in),
    .sda_in(sda_in), .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
    .control_reg_two(control_reg_two), .start_seen(start_seen), .stop_seen(),
    .buffer_full(buffer_full), .ack_status(ack_status), .port_irq_flag(port_irq_flag),
    .write_collision_flag(write_collision_flag), .bus_collision_flag(bus_collision_flag));
  i2c_slave_model slave (.core_clk(core_clk), .rst(rst), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .nack(nack), .stretch(stretch), .hold_low(hold_low), .scl_in(scl_in), .sda_in(sda_in),
    .rx_byte(rx_byte));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ctrl2(input logic [4:0] d);
    @(posedge core_clk);
    ctrl2_write <= 1'b1;
    ctrl2_write_data <= d;
    @(posedge core_clk);
    ctrl2_write <= 1'b0;
    #1;
  endtask
  task automatic buf_wr(input logic [7:0] d);
    @(posedge core_clk);
    buffer_write <= 1'b1;
    transfer_buffer <= d;
    @(posedge core_clk);
    buffer_write <= 1'b0;
    #1;
  endtask
  task automatic clear_all();
    @(posedge core_clk);
    irq_clear <= 1'b1;
    bc_clr <= 1'b1;
    wc_clr <= 1'b1;
    @(posedge core_clk);
    irq_clear <= 1'b0;
    bc_clr <= 1'b0;
    wc_clr <= 1'b0;
    #1;
  endtask
  // bounded wait for completion or collision
  task automatic wait_event();
    for (int i = 0; i < 3000; i++) begin
      if (port_irq_flag === 1'b1 || bus_collision_flag === 1'b1) break;
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic send(input logic [7:0] d, input logic n, input logic s);
    @(posedge core_clk);
    nack <= n;
    stretch <= s;
    buf_wr(d);
    chk("buffer_full", 8'h01, 8'(buffer_full));
    buf_wr(8'hFF);
    chk("write_collision_flag", 8'h01, 8'(write_collision_flag));
    ctrl2(5'h02);
    chk("control_reg_two", 8'h00, 8'(control_reg_two));
    wait_event();
    chk("port_irq_flag", 8'h01, 8'(port_irq_flag));
    chk("rx_byte", d, rx_byte);
    chk("ack_status", 8'(n), 8'(ack_status));
    chk("buffer_full", 8'h00, 8'(buffer_full));
    chk("scl_oe", 8'h01, 8'(scl_oe));
    clear_all();
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("start_seen", 8'h00, 8'(start_seen));
    @(posedge core_clk);
    port_enable_bit <= 1'b1;
    ctrl2(5'h01);
    buf_wr(8'h3C);
    chk("write_collision_flag", 8'h01, 8'(write_collision_flag));
    ctrl2(5'h02);
    chk("control_reg_two", 8'h01, 8'(control_reg_two));
    wait_event();
    chk("port_irq_flag", 8'h01, 8'(port_irq_flag));
    chk("control_reg_two", 8'h00, 8'(control_reg_two));
    chk("start_seen", 8'h01, 8'(start_seen));
    chk("sda_oe", 8'h01, 8'(sda_oe));
    chk("scl_oe", 8'h00, 8'(scl_oe));
    clear_all();
    send(8'hA4, 1'b0, 1'b0);
    send(8'h5B, 1'b1, 1'b1);
    ctrl2(5'h02);
    wait_event();
    chk("port_irq_flag", 8'h01, 8'(port_irq_flag));
    chk("control_reg_two", 8'h00, 8'(control_reg_two));
    chk("sda_oe", 8'h01, 8'(sda_oe));
    chk("bus_collision_flag", 8'h00, 8'(bus_collision_flag));
    clear_all();
    send(8'hA5, 1'b0, 1'b0);
    @(posedge core_clk);
    port_enable_bit <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("start_seen", 8'h00, 8'(start_seen));
    @(posedge core_clk);
    hold_low <= 1'b1;
    port_enable_bit <= 1'b1;
    ctrl2(5'h01);
    wait_event();
    chk("bus_collision_flag", 8'h01, 8'(bus_collision_flag));
    chk("control_reg_two", 8'h00, 8'(control_reg_two));
    chk("sda_oe", 8'h00, 8'(sda_oe));
    @(posedge core_clk);
    hold_low <= 1'b0;
    clear_all();
    @(posedge core_clk);
    port_mode_select <= i2c_master_pkg::MODE_FW_MASTER;
    ctrl2(5'h01);
    repeat (30) @(posedge core_clk);
    #1;
    chk("sda_oe", 8'h00, 8'(sda_oe));
    chk("scl_oe", 8'h00, 8'(scl_oe));
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
endmodule
